// ===== logic/ltr_params.svh
// Notes on behaviour
// R1 - remote loop retransmits serial input
// R2 - loopback still delivers parallel receive words
// R3 - remote loop only in transceiver mode
// R4 - repeater with monitor equals remote loopback
// R5 - pattern test enables generator and checker
// R6 - generated pattern enters parallel transmit path
// R7 - parallel transmit words ignored in pattern test
// R8 - each error drops check ok two word clocks
// R9 - power-on reset floats parallel receive word
// R10 - receive word clock legs low during reset
// R11 - reset length counted, one millisecond plus one clock
// R12 - partner holds enable low until stable
// R13 - or pulses enable low thirty nanoseconds
// R14 - frame sync lags data four to seven bits
// R15 - third spaced pattern raises sync four clocks
// R16 - enable low shuts down all logic
// R17 - same 31-stage polynomial, self-synchronizing checker
// R18 - check ok high unless error pulse shown
`ifndef LTR_PARAMS_SVH
`define LTR_PARAMS_SVH

// ==========================================================
// timing
`define LTR_CLK_PERIOD_NS   5
`define LTR_POR_TIME_NS     1000000
`define LTR_FRAME_TIME_NS   125000
`define LTR_ENABLE_LOW_NS   30
`define LTR_MCLK_PER_WORD   2
`define LTR_BITS_PER_WORD   4

// ==========================================================
// counts and widths
`define LTR_POR_CNT_W       18
`define LTR_FRM_CNT_W       14
`define LTR_ERR_HOLD        3'h4
`define LTR_SYNC_HOLD       4'h8
`define LTR_FRAME_HITS      2'h3
`define LTR_PRBS_LEN        31
`define LTR_PRBS_TAP        27
`define LTR_PRBS_SEED       31'h7fffffff
`define LTR_FILL_WORDS      4'h8
`define LTR_WORD_ZERO       4'h0

`endif

// ===== logic/ltr_pkg.sv
`default_nettype none
`include "ltr_params.svh"
package ltr_pkg;

   // ==========================================================
   // types
   typedef logic [3:0]  ltr_word_t;
   typedef logic [30:0] ltr_lfsr_t;

   // power-on sequence, gray along the usual path
   typedef enum logic [1:0] {
      POR_HOLD   = 2'h0,
      POR_RUN    = 2'h1,
      POR_ACTIVE = 2'h3
   } ltr_por_e;

   // configuration strap
   typedef enum logic [1:0] {
      MODE_TX_ONLY     = 2'h0,
      MODE_RX_ONLY     = 2'h1,
      MODE_TRANSCEIVER = 2'h2,
      MODE_REPEATER    = 2'h3
   } ltr_mode_e;

   // advance lfsr by one word, first bit in bit 3
   function automatic ltr_lfsr_t ltr_prbs_step(input ltr_lfsr_t s);
      ltr_lfsr_t n;
      n = s;
      for (int i = 0; i < `LTR_BITS_PER_WORD; i++) begin
         n = {n[`LTR_PRBS_LEN-2:0], n[`LTR_PRBS_LEN-1] ^ n[`LTR_PRBS_TAP]};
      end
      return n;
   endfunction : ltr_prbs_step

endpackage : ltr_pkg
`default_nettype wire

// ===== logic/ltr_prbs_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltr_params.svh"
module ltr_prbs_check
   import ltr_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      reset,
   input  wire logic      checkEnable,
   input  wire logic      wordTick,
   input  wire ltr_word_t rxWord,
   output logic           errFound,
   output logic           checkOk
);

   // ==========================================================
   // self-synchronizing prediction
   ltr_lfsr_t  history;
   logic [3:0] fill;
   logic [2:0] hold;
   logic       miss;
   ltr_lfsr_t  next_history;

   // predict each bit from past received bits
   always_comb begin
      next_history = history;
      miss         = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         miss         = miss | (rxWord[i] != (next_history[`LTR_PRBS_LEN-1] ^ next_history[`LTR_PRBS_TAP])); // see R17
         next_history = {next_history[`LTR_PRBS_LEN-2:0], rxWord[i]};
      end
   end

   assign errFound = checkEnable && wordTick && (fill == `LTR_FILL_WORDS) && miss;

   // history and fill tracking
   always_ff @(posedge mclk) begin
      if (reset || !checkEnable) begin
         history <= '0;
         fill    <= 4'h0;
      end else if (wordTick) begin
         history <= next_history;
         if (fill != `LTR_FILL_WORDS) begin
            fill <= fill + 4'h1;
         end
      end
   end

   // error stretch, retriggers on each error
   always_ff @(posedge mclk) begin
      if (reset) begin
         hold <= 3'h0;
      end else if (errFound) begin
         hold <= `LTR_ERR_HOLD; // see R8
      end else if (hold != 3'h0) begin
         hold <= hold - 3'h1;
      end
   end

   assign checkOk = (hold == 3'h0); // see R18

   // ==========================================================
   // checks
   a_err_low: assert property (@(posedge mclk) disable iff (reset) // see R8
      errFound |=> !checkOk [*4]) else $error("check ok not low for two word clocks");
   a_idle_high: assert property (@(posedge mclk) disable iff (reset) // see R18
      !checkEnable [*5] |-> checkOk) else $error("check ok low while test off");
   c_err_seen: cover property (@(posedge mclk) disable iff (reset) errFound);

endmodule : ltr_prbs_check
`default_nettype wire

// ===== logic/ltr_test_reset.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltr_params.svh"
module ltr_test_reset
   import ltr_pkg::*;
#(
   parameter int unsigned POR_CYCLES  = `LTR_POR_TIME_NS / `LTR_CLK_PERIOD_NS,
   parameter int unsigned FRAME_WORDS =
      `LTR_FRAME_TIME_NS / (`LTR_CLK_PERIOD_NS * `LTR_MCLK_PER_WORD)
)
(
   input  wire logic      mclk,
   input  wire logic      reset,
   input  wire logic      enable,
   input  wire ltr_mode_e configMode,
   input  wire logic      remoteLoopSelect,
   input  wire logic      rxMonitorSelect,
   input  wire logic      patternTestEnable,
   input  wire ltr_word_t txParallelWord,
   input  wire ltr_word_t rxSerialWord,
   input  wire logic      framePatternHit,
   output ltr_word_t      txSerialWord,
   output ltr_word_t      parallelRxWord,
   output logic           parallelRxWordOe,
   output logic           rxWordClockPos,
   output logic           rxWordClockNeg,
   output logic           frameFoundOut,
   output logic           patternCheckOk,
   output logic           porActive
);

   // ==========================================================
   // power-on sequence
   ltr_por_e porState;
   ltr_por_e next_porState;
   logic [`LTR_POR_CNT_W-1:0] porCount;
   logic active;

   assign active    = (porState == POR_ACTIVE);
   assign porActive = !active;

   // next state of the reset sequence
   always_comb begin
      case (porState)
         POR_HOLD:   next_porState = POR_RUN;
         POR_RUN:    next_porState = (porCount == `LTR_POR_CNT_W'(POR_CYCLES - 1)) ? POR_ACTIVE : POR_RUN; // see R11
         POR_ACTIVE: next_porState = POR_ACTIVE;
         default:    next_porState = POR_HOLD;
      endcase
   end

   // restart on supply reset or enable low
   always_ff @(posedge mclk) begin
      if (reset || !enable) begin
         porState <= POR_HOLD; // see R16
      end else begin
         porState <= next_porState;
      end
   end

   // reset length counter
   always_ff @(posedge mclk) begin
      if (reset || porState != POR_RUN) begin
         porCount <= '0;
      end else begin
         porCount <= porCount + `LTR_POR_CNT_W'(1); // see R11
      end
   end

   // ==========================================================
   // receive word clock, held low outside active
   logic wordTick;

   always_ff @(posedge mclk) begin
      if (reset || !active) begin
         rxWordClockPos <= 1'b0; // see R10
         rxWordClockNeg <= 1'b0;
      end else begin
         rxWordClockPos <= !rxWordClockPos;
         rxWordClockNeg <= rxWordClockPos;
      end
   end

   assign wordTick = active && !rxWordClockPos;

   // ==========================================================
   // path selection
   logic loopBack;
   logic retransmit;
   logic rxPathOn;
   logic txPathOn;

   assign loopBack   = ((configMode == MODE_TRANSCEIVER) && remoteLoopSelect) // see R3
                    || ((configMode == MODE_REPEATER) && rxMonitorSelect); // see R4
   assign retransmit = loopBack || (configMode == MODE_REPEATER);
   assign rxPathOn   = (configMode == MODE_RX_ONLY) || (configMode == MODE_TRANSCEIVER) || loopBack;
   assign txPathOn   = (configMode != MODE_RX_ONLY);

   // ==========================================================
   // pattern generator
   ltr_lfsr_t prbsState;
   ltr_lfsr_t prbsNext;

   assign prbsNext = ltr_prbs_step(prbsState); // see R17

   always_ff @(posedge mclk) begin
      if (reset || !patternTestEnable) begin
         prbsState <= `LTR_PRBS_SEED;
      end else if (wordTick) begin
         prbsState <= prbsNext; // see R5
      end
   end

   // ==========================================================
   // serial transmit word
   always_ff @(posedge mclk) begin
      if (reset || !active || !txPathOn) begin
         txSerialWord <= `LTR_WORD_ZERO;
      end else if (wordTick) begin
         if (retransmit) begin
            txSerialWord <= rxSerialWord; // see R1
         end else if (patternTestEnable) begin
            txSerialWord <= prbsNext[3:0]; // see R6, see R7
         end else begin
            txSerialWord <= txParallelWord;
         end
      end
   end

   // ==========================================================
   // parallel receive word and its enable
   always_ff @(posedge mclk) begin
      if (reset || !active) begin
         parallelRxWord   <= `LTR_WORD_ZERO;
         parallelRxWordOe <= 1'b0; // see R9
      end else begin
         parallelRxWordOe <= rxPathOn;
         if (wordTick) begin
            parallelRxWord <= rxSerialWord; // see R2
         end
      end
   end

   // ==========================================================
   // pattern checker
   logic errFound;

   ltr_prbs_check u_check (
      .mclk        (mclk),
      .reset       (reset),
      .checkEnable (patternTestEnable && active), // see R5
      .wordTick    (wordTick),
      .rxWord      (rxSerialWord),
      .errFound    (errFound),
      .checkOk     (patternCheckOk)
   );

   // ==========================================================
   // frame sync
   logic [`LTR_FRM_CNT_W-1:0] frameGap;
   logic [1:0]                hits;
   logic                      frameArm;
   logic [3:0]                syncHold;
   logic                      onTime;

   assign onTime = (frameGap == `LTR_FRM_CNT_W'(FRAME_WORDS - 1));

   // count spaced hits
   always_ff @(posedge mclk) begin
      if (reset || !active) begin
         frameGap <= '0;
         hits     <= 2'h0;
         frameArm <= 1'b0;
      end else if (wordTick) begin
         frameArm <= framePatternHit && (onTime || hits == 2'h0)
                  && (hits == `LTR_FRAME_HITS - 2'h1); // see R15
         if (framePatternHit) begin
            frameGap <= '0;
            if (hits == `LTR_FRAME_HITS - 2'h1) begin
               hits <= 2'h0;
            end else if (onTime || hits == 2'h0) begin
               hits <= hits + 2'h1;
            end else begin
               hits <= 2'h1;
            end
         end else if (!onTime) begin
            frameGap <= frameGap + `LTR_FRM_CNT_W'(1);
         end else begin
            frameGap <= '0;
            hits     <= 2'h0;
         end
      end
   end

   // pulse one word after aligned data
   always_ff @(posedge mclk) begin
      if (reset || !active) begin
         syncHold <= 4'h0;
      end else if (frameArm && wordTick) begin
         syncHold <= `LTR_SYNC_HOLD; // see R14, see R15
      end else if (syncHold != 4'h0) begin
         syncHold <= syncHold - 4'h1;
      end
   end

   assign frameFoundOut = (syncHold != 4'h0);

   // ==========================================================
   // checks
   a_por_quiet: assert property (@(posedge mclk) disable iff (reset) // see R9, see R10
      !active && !$past(active) |-> !parallelRxWordOe && !rxWordClockPos && !rxWordClockNeg)
      else $error("receive outputs live during reset");
   a_por_done: assert property (@(posedge mclk) disable iff (reset) // see R11
      porState == POR_RUN && porCount == `LTR_POR_CNT_W'(POR_CYCLES - 1) && enable |=> active)
      else $error("reset sequence did not end");
   a_loop_tx: assert property (@(posedge mclk) disable iff (reset) // see R1, see R4
      wordTick && loopBack && enable |=> txSerialWord == $past(rxSerialWord))
      else $error("loopback word not retransmitted");
   a_loop_rx: assert property (@(posedge mclk) disable iff (reset) // see R2
      wordTick && loopBack && enable |=> parallelRxWord == $past(rxSerialWord) && parallelRxWordOe)
      else $error("loopback word not delivered");
   a_loop_mode: assert property (@(posedge mclk) disable iff (reset) // see R3
      wordTick && enable && remoteLoopSelect && configMode == MODE_TX_ONLY && !patternTestEnable
      |=> txSerialWord == $past(txParallelWord))
      else $error("remote loop acted outside transceiver mode");
   a_prbs_tx: assert property (@(posedge mclk) disable iff (reset) // see R6, see R7
      wordTick && enable && patternTestEnable && !retransmit && txPathOn
      |=> txSerialWord == $past(prbsNext[3:0]))
      else $error("pattern not transmitted");
   a_sync_lag: assert property (@(posedge mclk) disable iff (reset) // see R14
      frameArm && wordTick && enable |=> frameFoundOut && !$past(frameFoundOut))
      else $error("frame sync not one word after data");
   a_sync_len: assert property (@(posedge mclk) disable iff (reset || !enable) // see R15
      $rose(frameFoundOut) |-> frameFoundOut [*8] ##1 !frameFoundOut)
      else $error("frame sync not four word clocks");
   a_off_quiet: assert property (@(posedge mclk) disable iff (reset) // see R16
      !enable |-> ##2 (!parallelRxWordOe && txSerialWord == `LTR_WORD_ZERO && !frameFoundOut))
      else $error("logic active while disabled");

   c_loop: cover property (@(posedge mclk) disable iff (reset) wordTick && loopBack);
   c_prbs: cover property (@(posedge mclk) disable iff (reset) wordTick && patternTestEnable);
   c_sync: cover property (@(posedge mclk) disable iff (reset) $rose(frameFoundOut));
   c_por: cover property (@(posedge mclk) disable iff (reset) $rose(active));

endmodule : ltr_test_reset
`default_nettype wire

// ===== verif/ltr_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far side of the serial line
module ltr_far_model
   import ltr_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      rxWordClockPos,
   input  wire ltr_word_t txSerialWord,
   input  wire logic      wrap,
   input  wire logic      flip,
   output ltr_word_t      rxSerialWord
);
   // new word each word clock; wrap returns tx, flip corrupts bit0
   initial begin
      rxSerialWord = 4'h0;
      forever begin
         @(negedge mclk);
         if (rxWordClockPos === 1'b1) begin
            rxSerialWord <= wrap ? (txSerialWord ^ {3'h0, flip}) : (rxSerialWord + 4'h3);
         end
      end
   end
endmodule : ltr_far_model
`default_nettype wire

// ===== verif/ltr_test_reset_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench top
module ltr_test_reset_tb_top
   import ltr_pkg::*;
;
   localparam int POR = 20;
   logic        mclk, reset, enable, remoteLoopSelect, rxMonitorSelect;
   logic        patternTestEnable, framePatternHit, wrap, flip;
   logic        parallelRxWordOe, rxWordClockPos, rxWordClockNeg, frameFoundOut, patternCheckOk, porActive;
   ltr_mode_e   configMode;
   ltr_word_t   txParallelWord, rxSerialWord, txSerialWord, parallelRxWord, takenRx, expTx;
   logic [30:0] hist;
   int          errTotal, numChecks, n, first, m;

   ltr_test_reset #(.POR_CYCLES(POR), .FRAME_WORDS(10)) ltr_test_reset_i (
      .mclk(mclk), .reset(reset), .enable(enable), .configMode(configMode),
      .remoteLoopSelect(remoteLoopSelect), .rxMonitorSelect(rxMonitorSelect),
      .patternTestEnable(patternTestEnable), .txParallelWord(txParallelWord),
      .rxSerialWord(rxSerialWord), .framePatternHit(framePatternHit), .txSerialWord(txSerialWord),
      .parallelRxWord(parallelRxWord), .parallelRxWordOe(parallelRxWordOe),
      .rxWordClockPos(rxWordClockPos), .rxWordClockNeg(rxWordClockNeg),
      .frameFoundOut(frameFoundOut), .patternCheckOk(patternCheckOk), .porActive(porActive));

   ltr_far_model ltr_far_model_i (
      .mclk(mclk), .rxWordClockPos(rxWordClockPos), .txSerialWord(txSerialWord),
      .wrap(wrap), .flip(flip), .rxSerialWord(rxSerialWord));

   // ==========================================================
   // helpers
   task automatic conclude();
      $display("checks %0d errors %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
      numChecks++;
      if (s !== e) begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // step one word: note the word taken, stop just after the tick
   task automatic nextw();
      int i;
      i = 0;
      do begin
         @(negedge mclk);
         i++;
      end while (rxWordClockPos !== 1'b0 && i < 4);
      if (rxWordClockPos !== 1'b0) begin
         chk("wordClock", 0, rxWordClockPos);
         conclude();
      end
      takenRx = rxSerialWord;
      @(negedge mclk);
   endtask : nextw

   // wait for start-up to finish and check its length
   task automatic porUp();
      int i;
      for (i = 0; i < 40 && porActive !== 1'b0; i++) @(negedge mclk);
      chk("porLen", 1, i >= POR && i <= POR + 4);
      if (porActive !== 1'b0) begin
         conclude();
      end
   endtask : porUp

   // ==========================================================
   // clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ==========================================================
   // main sequence
   initial begin
      errTotal = 0;
      numChecks = 0;
      hist = '0;
      reset = 1'b1;
      enable = 1'b0;
      configMode = MODE_TRANSCEIVER;
      remoteLoopSelect = 1'b0;
      rxMonitorSelect = 1'b0;
      patternTestEnable = 1'b0;
      txParallelWord = 4'h0;
      framePatternHit = 1'b0;
      wrap = 1'b0;
      flip = 1'b0;
      repeat (3) @(negedge mclk);
      chk("rstOe", 0, parallelRxWordOe);
      chk("rstClk", 0, {rxWordClockPos, rxWordClockNeg});
      chk("rstOk", 1, patternCheckOk);
      reset = 1'b0;
      enable = 1'b1;
      porUp();
      // every mode with loop and monitor on, transceiver and repeater also with both off
      for (int k = 0; k < 6; k++) begin
         m = (k < 4) ? k : k - 2;
         configMode = ltr_mode_e'(m[1:0]);
         remoteLoopSelect = (k < 4);
         rxMonitorSelect = (k < 4);
         txParallelWord = 4'h9 + 4'(k);
         nextw();
         nextw();
         expTx = (m == 0 || k == 4) ? txParallelWord : ((m == 1) ? 4'h0 : takenRx);
         chk("txWord", expTx, txSerialWord);
         chk("clkLegs", 4'h2, {rxWordClockPos, rxWordClockNeg});
         chk("rxOe", m != 0 && k != 5, parallelRxWordOe);
         if (m != 0 && k != 5) chk("rxWord", takenRx, parallelRxWord);
      end
      // chip disable quiets outputs and restarts start-up
      enable = 1'b0;
      repeat (7) @(negedge mclk);
      chk("offOe", 0, parallelRxWordOe);
      chk("offClk", 0, {rxWordClockPos, rxWordClockNeg});
      chk("offTx", 0, txSerialWord);
      chk("offPor", 1, porActive);
      enable = 1'b1;
      porUp();
      // pattern test over a wrapped line
      configMode = MODE_TRANSCEIVER;
      remoteLoopSelect = 1'b0;
      txParallelWord = 4'h5;
      wrap <= 1'b1;
      patternTestEnable = 1'b1;
      for (int w = 0; w < 30; w++) begin
         nextw();
         for (int j = 3; j >= 0; j--) begin
            if (w >= 10) chk("prbs", hist[30] ^ hist[27], txSerialWord[j]);
            hist = {hist[29:0], txSerialWord[j]};
         end
         if (w >= 20) chk("okHigh", 1, patternCheckOk);
      end
      flip <= 1'b1;
      nextw();
      flip <= 1'b0;
      for (first = 0; first < 12 && patternCheckOk !== 1'b0; first++) @(negedge mclk);
      if (patternCheckOk !== 1'b0) begin
         chk("okDrop", 0, patternCheckOk);
         conclude();
      end
      n = 0;
      repeat (8) begin
         n += (patternCheckOk === 1'b0);
         @(negedge mclk);
      end
      chk("okLow", 4, 4'(n));
      patternTestEnable = 1'b0;
      wrap <= 1'b0;
      repeat (12) nextw();
      chk("okIdle", 1, patternCheckOk);
      // three framing hits one frame apart
      for (int h = 0; h < 3; h++) begin
         framePatternHit = 1'b1;
         nextw();
         framePatternHit = 1'b0;
         if (h < 2) begin
            chk("fsEarly", 0, frameFoundOut);
            repeat (9) nextw();
         end
      end
      first = 0;
      n = 0;
      for (int i = 1; i <= 11; i++) begin
         @(negedge mclk);
         if (frameFoundOut === 1'b1) begin
            n++;
            if (first == 0) first = i;
         end
      end
      chk("fsLag", 2, 4'(first));
      chk("fsLen", 8, 4'(n));
      conclude();
   end
endmodule : ltr_test_reset_tb_top
`default_nettype wire
